// file: quad_dac_serial_control.sv
`timescale 1ns/100ps
// Functional notes
// [R1] one 16-bit shift register captures serial input and feeds the serial output
// [R2] each of four 12-bit channels has staging input and converter registers
// [R3] word is two address, two control, twelve data bits, msb first
// [R4] clear zeroes the data and control registers, reloads the settling count, and forces converter codes, user output, echo low
// [R5] serial interface responds only while chip select is low
// [R6] lockout low ignores shutdown commands and keeps normal operation
// [R7] top nibble 1100 enters shutdown when lockout is high
// [R8] serial interface keeps shifting and executing words during shutdown
// [R9] entering shutdown leaves the input registers untouched
// [R10] restore from inputs or load new data leaves shutdown
// [R11] host waits the settling time after power-up or shutdown exit
// [R12] shutdown asserts the high-impedance control, released on exit
// [R13] shift register contents leave on the echo output for readback
// [R14] commands load input alone, converters directly, or all converters together
// [R15] bits shift on rising serial clock; command acts on chip select rise
// [R16] control 01 load, 11 load and update, 0100, 1000, 0000 decode
// [R17] mode 0 echo on falling edges lag 16.5, mode 1 rising lag 16
// [R18] code 0010 drives user output low, 0110 drives it high
// [R19] extra clocks in a frame: last sixteen bits are acted on
// [R20] clear is asynchronous, aborts transfers, restores mode 0 and low user output
module quad_dac_serial_control #(
	parameter logic [dac_ctl_pkg::SETTLE_W-1:0] SETTLE_CYCLES =
		dac_ctl_pkg::SETTLE_CYC[dac_ctl_pkg::SETTLE_W-1:0]
) (
	input  wire logic                                                  MCLK,
	input  wire logic                                                  RST_B,
	input  wire logic                                                  SCLK,
	input  wire logic                                                  CS_B,
	input  wire logic                                                  DIN,
	input  wire logic                                                  CLEAR_ALL_N,
	input  wire logic                                                  SHUTDOWN_LOCKOUT_N,
	output      logic                                                  DOUT,
	output      logic                                                  USER_LOGIC_OUT,
	output      logic                                                  SHUTDOWN_HIZ,
	output      logic                                                  DOUT_MODE,
	output      logic                                                  OUTPUT_SETTLING,
	output      logic [dac_ctl_pkg::NUM_CH-1:0][dac_ctl_pkg::DATA_W-1:0] CONV_CODE
);
	import dac_ctl_pkg::*;

	logic                arst_n;
	logic                rst_meta_r;
	logic                rst_n_r;
	logic [PIN_W-1:0]    pin_raw;
	logic [PIN_W-1:0]    pin_meta_r;
	logic [PIN_W-1:0]    pin_sync_r;
	logic [PIN_W-1:0]    pin_prev_r;
	logic                sclk_rise;
	logic                sclk_fall;
	logic                cs_low;
	logic                cs_rise;
	logic                din_s;
	logic                lock_s;
	logic [WORD_W-1:0]   sr_r;
	logic [WORD_W-1:0]   sr_nxt;
	logic                tail_r;
	logic                tail_nxt;
	logic                dout_r;
	logic                dout_nxt;
	logic                mode_r;
	logic                mode_nxt;
	logic                user_out_r;
	logic                user_out_nxt;
	logic                sd_r;
	logic                sd_nxt;
	logic [SETTLE_W-1:0] settle_r;
	logic [SETTLE_W-1:0] settle_nxt;
	logic                busy_r;
	logic                busy_nxt;
	logic [NUM_CH-1:0]   we_c;
	logic                upd_c;

	chan_bank_if bank_bus ();

	// clear pin and system reset share one net: assert at once, release on MCLK
	assign arst_n = RST_B & CLEAR_ALL_N;

	always_ff @(posedge MCLK or negedge arst_n) begin // [R20]
		if (!arst_n) begin
			rst_meta_r <= 1'h0;
			rst_n_r    <= 1'h0;
		end else begin
			rst_meta_r <= 1'h1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// every pin passes two flops; the third stage only serves edge detection
	assign pin_raw = {SCLK, CS_B, DIN, SHUTDOWN_LOCKOUT_N};

	always_ff @(posedge MCLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_meta_r <= PIN_IDLE;
			pin_sync_r <= PIN_IDLE;
			pin_prev_r <= PIN_IDLE;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// edges of the serial clock and chip select, seen in the MCLK domain
	always_comb begin
		sclk_rise = pin_sync_r[PIN_SCLK] & ~pin_prev_r[PIN_SCLK];
		sclk_fall = ~pin_sync_r[PIN_SCLK] & pin_prev_r[PIN_SCLK];
		cs_low    = ~pin_sync_r[PIN_CS]; // [R5]
		cs_rise   = pin_sync_r[PIN_CS] & ~pin_prev_r[PIN_CS]; // [R15]
		din_s     = pin_sync_r[PIN_DIN];
		lock_s    = pin_sync_r[PIN_LOCK];
	end

	// shift path; shutdown does not gate it, so words still arrive
	always_comb begin // [R8]
		sr_nxt   = sr_r;
		tail_nxt = tail_r;
		dout_nxt = dout_r;
		if (cs_low && sclk_rise) begin
			sr_nxt   = {sr_r[WORD_W-2:0], din_s}; // [R1]
			tail_nxt = sr_r[WORD_W-1];
			if (mode_r) begin
				dout_nxt = sr_r[WORD_W-1]; // [R17]
			end
		end
		// half a clock later than the rising-edge tail, giving the 16.5 lag
		if (cs_low && sclk_fall && !mode_r) begin
			dout_nxt = tail_r; // [R17]
		end
	end

	always_ff @(posedge MCLK or negedge rst_n_r) begin // [R4]
		if (!rst_n_r) begin
			sr_r   <= WORD_RST;
			tail_r <= 1'h0;
			dout_r <= 1'h0;
		end else begin
			sr_r   <= sr_nxt;
			tail_r <= tail_nxt;
			dout_r <= dout_nxt;
		end
	end

	// command decode at chip select rise on whatever sixteen bits remain
	always_comb begin // [R19]
		mode_nxt = mode_r;
		user_out_nxt = user_out_r;
		sd_nxt   = sd_r;
		we_c     = '0;
		upd_c    = 1'h0;
		if (cs_rise) begin
			if (sr_r[CTL_LO_POS]) begin
				// control 01 loads one input, 11 also updates every converter
				we_c[{sr_r[ADDR_HI_POS], sr_r[ADDR_LO_POS]}] = 1'h1; // [R3]
				upd_c = sr_r[CTL_HI_POS]; // [R16]
			end else begin
				unique case (cmd_t'(cmd_of(sr_r)))
					CMD_NO_OPERATION: begin
					end
					CMD_UPD_ALL: begin
						upd_c = 1'h1; // [R14]
					end
					CMD_LOAD_ALL: begin
						we_c  = ALL_CH; // [R16]
						upd_c = 1'h1;
					end
					CMD_SHDN: begin
						if (lock_s) begin
							sd_nxt = 1'h1; // [R7]
						end
					end
					CMD_USER_LO: begin
						user_out_nxt = 1'h0; // [R18]
					end
					CMD_USER_HI: begin
						user_out_nxt = 1'h1; // [R18]
					end
					CMD_MODE0: begin
						mode_nxt = 1'h0;
						upd_c    = 1'h1;
					end
					CMD_MODE1: begin
						mode_nxt = 1'h1;
						upd_c    = 1'h1;
					end
					default: begin
					end
				endcase
			end
		end
		// any converter update brings the part back up
		if (upd_c) begin
			sd_nxt = 1'h0; // [R10]
		end
		// lockout low wakes the part and blocks new shutdowns
		if (!lock_s) begin
			sd_nxt = 1'h0; // [R6]
		end
	end

	always_ff @(posedge MCLK or negedge rst_n_r) begin // [R20]
		if (!rst_n_r) begin
			mode_r     <= MODE_RST;
			user_out_r <= USER_OUT_RST;
			sd_r       <= 1'h0;
		end else begin
			mode_r     <= mode_nxt;
			user_out_r <= user_out_nxt;
			sd_r   <= sd_nxt;
		end
	end

	// settling flag: counts from reset release and from each shutdown exit
	always_comb begin // [R11]
		settle_nxt = settle_r;
		if (sd_r && !sd_nxt) begin
			settle_nxt = SETTLE_CYCLES;
		end else if (settle_r != '0) begin
			settle_nxt = settle_r - SETTLE_W'(1);
		end
		busy_nxt = sd_nxt || (settle_nxt != '0);
	end

	always_ff @(posedge MCLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			settle_r <= SETTLE_CYCLES;
			busy_r   <= 1'h1;
		end else begin
			settle_r <= settle_nxt;
			busy_r   <= busy_nxt;
		end
	end

	// write strobes travel to the channel bank; no shutdown term, so inputs survive
	assign bank_bus.in_we   = we_c; // [R9]
	assign bank_bus.wdata   = sr_r[DATA_W-1:0];
	assign bank_bus.upd_all = upd_c;

	chan_regs u_chan_regs (
		.clk   (MCLK),
		.rst_n (rst_n_r),
		.bus   (bank_bus.bank)
	);

	// every output straight from a flop
	assign DOUT            = dout_r; // [R13]
	assign USER_LOGIC_OUT  = user_out_r;
	assign SHUTDOWN_HIZ    = sd_r; // [R12]
	assign DOUT_MODE       = mode_r;
	assign OUTPUT_SETTLING = busy_r;
	assign CONV_CODE       = bank_bus.conv_code;

	// shift path and echo timing, judged one system clock after each serial edge
	AST_SHIFT_IN: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R1]
		(cs_low && sclk_rise) |=> (sr_r == {$past(sr_r[WORD_W-2:0]), $past(din_s)}))
		else $error("shift register did not take the input bit");
	AST_CS_HIGH_IDLE: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R5]
		(!cs_low) |=> $stable(sr_r))
		else $error("shift register moved with chip select high");
	AST_MODE1_ECHO: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R17]
		(mode_r && cs_low && sclk_rise) |=> (DOUT == $past(sr_r[WORD_W-1])))
		else $error("mode 1 echo bit wrong");
	AST_MODE0_ECHO: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R17]
		(!mode_r && cs_low && sclk_rise) |=> $stable(DOUT))
		else $error("mode 0 echo moved on a rising serial clock edge");
	AST_MODE0_FALL: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R17]
		(!mode_r && cs_low && sclk_fall) |=> (DOUT == $past(tail_r)))
		else $error("mode 0 echo bit wrong");
	AST_LOCKOUT: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R6]
		(!lock_s) |=> !SHUTDOWN_HIZ)
		else $error("shutdown while lockout low");
	AST_SHDN_ENTER: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R7]
		(cs_rise && !sr_r[CTL_LO_POS] && cmd_of(sr_r) == CMD_SHDN && lock_s)
		|=> SHUTDOWN_HIZ ##1 (SHUTDOWN_HIZ || $past(!lock_s) || $past(upd_c)))
		else $error("shutdown command not taken");
	AST_SHDN_EXIT: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R10]
		(cs_rise && SHUTDOWN_HIZ && cmd_of(sr_r) == CMD_UPD_ALL)
		|=> (!SHUTDOWN_HIZ && OUTPUT_SETTLING))
		else $error("restore did not leave shutdown");
	AST_USER_HIGH: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R18]
		(cs_rise && !sr_r[CTL_LO_POS] && cmd_of(sr_r) == CMD_USER_HI)
		|=> USER_LOGIC_OUT ##1 (USER_LOGIC_OUT || $past(cs_rise)))
		else $error("user output not driven high");
	AST_CLEAR_OUT: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R4]
		$rose(rst_n_r) |-> (!USER_LOGIC_OUT && !DOUT && !SHUTDOWN_HIZ && !DOUT_MODE
		&& CONV_CODE == '0))
		else $error("outputs not cleared");
	// command effects as seen on the ports one clock after the decode
	AST_USER_LOW: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R18]
		(cs_rise && cmd_of(sr_r) == CMD_USER_LO) |=> !USER_LOGIC_OUT)
		else $error("user output not driven low");
	AST_MODE1_SELECT: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R17]
		(cs_rise && cmd_of(sr_r) == CMD_MODE1) |=> DOUT_MODE)
		else $error("mode 1 not selected");
	AST_LOAD_ALL: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R16]
		(cs_rise && cmd_of(sr_r) == CMD_LOAD_ALL)
		|=> (CONV_CODE == {NUM_CH{$past(sr_r[DATA_W-1:0])}}))
		else $error("load all did not reach every converter");
	AST_NO_OPERATION: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R16]
		(cs_rise && cmd_of(sr_r) == CMD_NO_OPERATION) |=> $stable(CONV_CODE))
		else $error("converter codes moved on an empty command");
	AST_ECHO_IDLE: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R5]
		(!cs_low) |=> $stable(DOUT))
		else $error("echo output moved with chip select high");
	AST_HIZ_CAUSE: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R12]
		$rose(SHUTDOWN_HIZ) |-> ($past(cs_rise) && $past(lock_s)))
		else $error("shutdown entered without a command");
	AST_SETTLE_ON_EXIT: assert property (@(posedge MCLK) disable iff (!rst_n_r) // [R11]
		$fell(SHUTDOWN_HIZ) |-> OUTPUT_SETTLING)
		else $error("settling flag low after shutdown exit");
endmodule : quad_dac_serial_control

// file: dac_ctl_pkg.sv
package dac_ctl_pkg;
	// word layout, sent msb first
	localparam int WORD_W      = 16;
	localparam int DATA_W      = 12;
	localparam int NUM_CH      = 4;
	localparam int ADDR_HI_POS = 15;
	localparam int ADDR_LO_POS = 14;
	localparam int CTL_HI_POS  = 13;
	localparam int CTL_LO_POS  = 12;
	localparam int CMD_LSB     = 12;

	// synchronised pin vector positions and idle values
	localparam int PIN_W     = 4;
	localparam int PIN_SCLK  = 3;
	localparam int PIN_CS    = 2;
	localparam int PIN_DIN   = 1;
	localparam int PIN_LOCK  = 0;
	localparam logic [PIN_W-1:0] PIN_IDLE = 4'h5;

	// reset values
	localparam logic              MODE_RST     = 1'h0;
	localparam logic              USER_OUT_RST = 1'h0;
	localparam logic [DATA_W-1:0] CODE_RST = 12'h000;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [NUM_CH-1:0] ALL_CH   = 4'hF;

	// output settling time after power-up or shutdown exit
	localparam int SETTLE_US  = 20;
	localparam int MCLK_MHZ   = 125;
	localparam int SETTLE_W   = 12;
	localparam int SETTLE_CYC = SETTLE_US * MCLK_MHZ;

	// address/control nibble of the commands whose low control bit is zero
	typedef enum logic [3:0] {
		CMD_NO_OPERATION = 4'h0,
		CMD_USER_LO      = 4'h2,
		CMD_UPD_ALL      = 4'h4,
		CMD_USER_HI      = 4'h6,
		CMD_LOAD_ALL = 4'h8,
		CMD_MODE0    = 4'hA,
		CMD_SHDN     = 4'hC,
		CMD_MODE1    = 4'hE
	} cmd_t;

	function automatic logic [3:0] cmd_of(input logic [WORD_W-1:0] w);
		cmd_of = w[WORD_W-1:CMD_LSB];
	endfunction : cmd_of
endpackage : dac_ctl_pkg

// file: chan_bank_if.sv
`timescale 1ns/100ps
interface chan_bank_if;
	import dac_ctl_pkg::*;
	logic [NUM_CH-1:0]             in_we;
	logic [DATA_W-1:0]             wdata;
	logic                          upd_all;
	logic [NUM_CH-1:0][DATA_W-1:0] conv_code;

	modport ctrl (output in_we, output wdata, output upd_all, input conv_code);
	modport bank (input in_we, input wdata, input upd_all, output conv_code);
endinterface : chan_bank_if

// file: chan_regs.sv
`timescale 1ns/100ps
module chan_regs (
	input  wire logic  clk,
	input  wire logic  rst_n,
	chan_bank_if.bank  bus
);
	import dac_ctl_pkg::*;

	logic [NUM_CH-1:0][DATA_W-1:0] in_r;
	logic [NUM_CH-1:0][DATA_W-1:0] in_nxt;
	logic [NUM_CH-1:0][DATA_W-1:0] conv_r;
	logic [NUM_CH-1:0][DATA_W-1:0] conv_nxt;

	// staging register, then converter register fed from the new staging value
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		assign in_nxt[i]   = bus.in_we[i] ? bus.wdata : in_r[i];
		assign conv_nxt[i] = bus.upd_all ? in_nxt[i] : conv_r[i]; // [R2]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_r   <= {NUM_CH{CODE_RST}};
			conv_r <= {NUM_CH{CODE_RST}};
		end else begin
			in_r   <= in_nxt;
			conv_r <= conv_nxt;
		end
	end

	assign bus.conv_code = conv_r;

	AST_INPUT_HELD: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
		(bus.in_we == '0) |=> $stable(in_r))
		else $error("input register changed without a write");
	AST_UPDATE_ALL: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		bus.upd_all |=> (conv_r == in_r))
		else $error("converter registers differ from inputs after update");
	AST_LOAD_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
		(bus.in_we != '0 && !bus.upd_all) |=> $stable(conv_r))
		else $error("converter register moved on an input-only load");
endmodule : chan_regs

// file: serial_host.sv
`timescale 1ns/100ps
// behavioural serial master on the far side of the link
module serial_host (
	input  wire logic mclk,
	input  wire logic dout,
	output      logic sclk,
	output      logic cs_b,
	output      logic din
);
	// link clock rests low and select high between frames
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		din  = 1'b0;
	end

	// half of the 80 ns link period, moved on system clock falls
	task automatic half();
		repeat (5) @(negedge mclk);
	endtask : half

	// shift the low n bits of w, msb first; readback is sampled half a period
	// after each fall in mode 0 and just before each fall in mode 1
	task automatic xfer(input logic [31:0] w, input int n, input logic sel,
		input logic mode, output logic [31:0] echo);
		echo = 32'h0;
		cs_b = ~sel;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			din = w[i];
			half();
			if (!mode) echo = {echo[30:0], dout};
			sclk = 1'b1;
			half();
			if (mode) echo = {echo[30:0], dout};
			sclk = 1'b0;
		end
		half();
		// mode 0 moves the echo on falls, so its last bit follows the last fall
		if (!mode) echo = {echo[30:0], dout};
		cs_b = 1'b1;
		// released data line must not look like a held bit
		din = ~din;
		repeat (8) @(negedge mclk);
	endtask : xfer
endmodule : serial_host

// file: quad_dac_serial_control_tb.sv
`timescale 1ns/100ps
module quad_dac_serial_control_tb;
	import dac_ctl_pkg::*;
	logic                          mclk;
	logic                          rst_b;
	logic                          clr_n;
	logic                          lock_n;
	logic                          sclk;
	logic                          cs_b;
	logic                          din;
	logic                          dout;
	logic                          user_out;
	logic                          hiz;
	logic                          mode;
	logic                          settling;
	logic [NUM_CH-1:0][DATA_W-1:0] code;
	logic [NUM_CH-1:0][DATA_W-1:0] exp_in;
	logic [31:0]                   echo;
	logic                          mode_e;
	int                            n_errors;
	int                            n_checks;

	// short settling count keeps the run brief
	quad_dac_serial_control #(.SETTLE_CYCLES(12'h008)) dut (
		.MCLK(mclk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .DIN(din),
		.CLEAR_ALL_N(clr_n), .SHUTDOWN_LOCKOUT_N(lock_n), .DOUT(dout),
		.USER_LOGIC_OUT(user_out), .SHUTDOWN_HIZ(hiz), .DOUT_MODE(mode),
		.OUTPUT_SETTLING(settling), .CONV_CODE(code));

	serial_host host (.mclk(mclk), .dout(dout), .sclk(sclk), .cs_b(cs_b), .din(din));

	// 125 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] want);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("CHECK FAILED at %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	// one selected 16-bit word: command nibble then data
	task automatic send(input logic [3:0] c, input logic [11:0] d);
		host.xfer({16'h0000, c, d}, 16, 1'b1, mode_e, echo);
	endtask : send

	// the settling flag is still up while the host waits after reset
	task automatic t_reset();
		check(code, 48'h0);
		check({user_out, hiz, mode, dout}, 4'h0);
		check(settling, 1'b1);
	endtask : t_reset

	// staging loads leave converters alone until an update
	task automatic t_load();
		for (int ch = 0; ch < NUM_CH; ch++) begin
			exp_in[ch] = 12'h1A5 + 12'(ch);
			send({2'(ch), 2'b01}, exp_in[ch]);
			check(code, 48'h0);
		end
		send(CMD_UPD_ALL, 12'hFFF);
		check(code, exp_in);
		exp_in[2] = 12'hABC;
		send(4'hB, 12'hABC);
		check(code, exp_in);
	endtask : t_load

	// clocks with select high must change nothing
	task automatic t_unsel();
		host.xfer(32'h0000_8FFF, 16, 1'b0, mode_e, echo);
		check(code, exp_in);
	endtask : t_unsel

	// twenty clocks: only the last sixteen bits count
	task automatic t_long();
		exp_in[0] = 12'hC3D;
		host.xfer(32'h000F_3C3D, 20, 1'b1, mode_e, echo);
		check(code, exp_in);
	endtask : t_long

	// settling is judged during shutdown and right after the restore exit, while the host still waits
	task automatic t_shdn();
		lock_n = 1'b0;
		send(CMD_SHDN, 12'h000);
		check(hiz, 1'b0);
		lock_n = 1'b1;
		send(CMD_SHDN, 12'hFFF);
		check(hiz, 1'b1);
		check(settling, 1'b1);
		exp_in[1] = 12'h321;
		send(4'h5, 12'h321);
		check(hiz, 1'b1);
		send(CMD_UPD_ALL, 12'h000);
		check(hiz, 1'b0);
		check(settling, 1'b1);
		check(code, exp_in);
		send(CMD_SHDN, 12'h000);
		exp_in = {NUM_CH{12'h5A5}};
		send(CMD_LOAD_ALL, 12'h5A5);
		check(hiz, 1'b0);
		check(code, exp_in);
		send(CMD_UPD_ALL, 12'h000);
		check(code, exp_in);
	endtask : t_shdn

	task automatic t_upo();
		send(CMD_USER_HI, 12'h000);
		check(user_out, 1'b1);
		check(settling, 1'b0);
		send(CMD_USER_LO, 12'hFFF);
		check(user_out, 1'b0);
	endtask : t_upo

	// readback of the previous word in both echo modes
	task automatic t_echo();
		exp_in[3] = 12'h7E1;
		send(4'hD, 12'h7E1);
		send(CMD_MODE1, 12'h000);
		check(mode, 1'b1);
		check(code, exp_in);
		mode_e = 1'b1;
		send(4'h1, 12'h2B4);
		exp_in[0] = 12'h2B4; // staged here, reaches the converter on the mode 0 update
		send(CMD_NO_OPERATION, 12'h000);
		check(echo[15:0], 16'h12B4);
		send(CMD_MODE0, 12'h000);
		check(mode, 1'b0);
		mode_e = 1'b0;
		send(4'h9, 12'h6C3);
		send(CMD_NO_OPERATION, 12'h000);
		check(echo[15:0], 16'h96C3);
		check(code, exp_in);
	endtask : t_echo

	// clear wipes codes and restores mode 0 and a low user output
	task automatic t_clear();
		send(CMD_USER_HI, 12'h000);
		send(CMD_MODE1, 12'h000);
		clr_n = 1'b0;
		repeat (3) @(negedge mclk);
		check(code, 48'h0);
		check({user_out, hiz, mode, dout}, 4'h0);
		clr_n = 1'b1;
		repeat (8) @(negedge mclk);
		check(mode, 1'b0);
	endtask : t_clear

	initial begin
		rst_b    = 1'b0;
		clr_n    = 1'b1;
		lock_n   = 1'b1;
		mode_e   = 1'b0;
		exp_in   = '0;
		n_errors = 0;
		n_checks = 0;
		repeat (12) @(negedge mclk);
		rst_b = 1'b1;
		repeat (6) @(negedge mclk);
		t_reset();
		t_load();
		t_unsel();
		t_long();
		t_shdn();
		t_upo();
		t_echo();
		t_clear();
		close_out();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge mclk);
		n_errors++;
		close_out();
	end
endmodule : quad_dac_serial_control_tb
